// File: src/port_expander_defines.svh
// constants for the timed output port expander
// assumes a 40 MHz system clock feeding every register
`ifndef PORT_EXPANDER_DEFINES_SVH
`define PORT_EXPANDER_DEFINES_SVH

// ==========================================================
// serial address layout
`define DEV_CODE 3'h4
`define ADDR_BITS 4'h8

// ==========================================================
// command codes
`define CMD_CTRL 4'h0
`define CMD_NV_DEF 4'h1
`define CMD_NV_DLY0 4'h2
`define CMD_NV_LAST 4'h5
`define NV_SLOTS 5

// ==========================================================
// reset values
`define CTRL_RESET 8'h00

// ==========================================================
// timing: delay unit of the lower channels
`define CLK_NS 25
`define TICK_NS 1000
`define TICK_CYC ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define SCL_MAX_KHZ 400

`endif

// File: src/port_expander_pkg.sv
// types shared by the port expander core and its storage
// assumes the defines header is compiled alongside
package port_expander_pkg;

  // ========================================================
  // serial interface states, gray along the usual path
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_addr_ack = 3'h3,
    st_wdata = 3'h2,
    st_wack = 3'h6,
    st_rdata = 3'h7,
    st_rack = 3'h5
  } serial_state_t;

  // ========================================================
  // nonvolatile contents: slot 0 defaults, slots 1..4 delays
  typedef logic [4:0][7:0] nv_array_t;

  // write request towards the nonvolatile store
  typedef struct packed {
    logic we;
    logic [2:0] addr;
    logic [7:0] data;
  } nv_req_t;

  // whole state of the core
  typedef struct packed {
    serial_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [3:0] cmd;
    logic rw;
    logic drive_low;
    logic ack_seen;
    logic [7:0] ctrl;
    logic booted;
    logic timer_enable_in_q;
    logic running;
    logic [5:0] tick_cnt;
    logic [7:0] elapsed;
    logic [3:0] inv;
    logic [7:0] dout;
    logic scl_q;
    logic sda_q;
    nv_req_t nv;
  } core_state_t;

endpackage

// File: src/nv_store.sv
// nonvolatile default and delay storage
// assumes writes arrive as single-cycle requests from the core
`timescale 1ns/1ps
`include "port_expander_defines.svh"

module nv_store
(
  input wire logic sys_clk,
  input wire logic wp_in,
  input wire port_expander_pkg::nv_req_t req,
  output port_expander_pkg::nv_array_t contents
);
  import port_expander_pkg::*;

  nv_array_t mem = '0;
  nv_array_t next_mem;

  // ========================================================
  // store update, refused while write protect is high
  always_comb
  begin
    next_mem = mem;
    if (req.we && !wp_in && (req.addr < 3'(`NV_SLOTS)))
    begin
      next_mem[req.addr] = req.data;
    end
  end

  // contents are not cleared by reset so they survive it
  always_ff @(posedge sys_clk)
  begin
    mem <= next_mem;
  end

  assign contents = mem;

endmodule

// File: src/timed_output_port_expander.sv
// timed output port expander core: serial slave, timer, outputs
// assumes scl, sda and timer enable are synchronous to sys_clk
`timescale 1ns/1ps
`include "port_expander_defines.svh"

module timed_output_port_expander
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic wp_in,
  input wire logic timer_enable_in,
  output logic timed_out_0,
  output logic timed_out_1,
  output logic timed_out_2,
  output logic timed_out_3,
  output logic fixed_out_4,
  output logic fixed_out_5,
  output logic fixed_out_6,
  output logic fixed_out_7
);
  import port_expander_pkg::*;

  core_state_t st;
  core_state_t next_st;
  nv_array_t nv;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic timer_enable_in_rise;
  logic tick;
  logic [3:0] due;

  // ========================================================
  // decoding shared by reads and writes
  function automatic logic nv_cmd(input logic [3:0] cmd);
    nv_cmd = (cmd >= `CMD_NV_DEF) && (cmd <= `CMD_NV_LAST);
  endfunction

  function automatic logic [2:0] nv_slot(input logic [3:0] cmd);
    logic [3:0] diff;
    diff = cmd - `CMD_NV_DEF;
    nv_slot = diff[2:0];
  endfunction

  // ========================================================
  // nonvolatile storage
  nv_store u_nv
  (
    .sys_clk(sys_clk),
    .wp_in(wp_in),
    .req(st.nv),
    .contents(nv)
  );

  // ========================================================
  // bus edges; 40 MHz sampling covers 400 kHz scl with margin
  assign scl_rise = scl_in && !st.scl_q;
  assign scl_fall = !scl_in && st.scl_q;
  assign start_seen = scl_in && st.scl_q && st.sda_q && !sda_in;
  assign stop_seen = scl_in && st.scl_q && !st.sda_q && sda_in;
  assign timer_enable_in_rise = timer_enable_in && !st.timer_enable_in_q;
  assign tick = st.tick_cnt == 6'(`TICK_CYC - 1);

  // per channel delay comparison
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_due
      assign due[gi] = st.elapsed >= nv[gi + 1];
    end
  endgenerate

  // ========================================================
  // next state
  always_comb
  begin
    logic [7:0] rd;
    rd = 8'h00;
    next_st = st;
    next_st.scl_q = scl_in;
    next_st.sda_q = sda_in;
    next_st.timer_enable_in_q = timer_enable_in;
    next_st.nv.we = 1'b0;
    if (st.cmd == `CMD_CTRL)
    begin
      rd = st.ctrl;
    end
    else if (nv_cmd(st.cmd))
    begin
      rd = nv[nv_slot(st.cmd)];
    end

    // serial slave
    if (start_seen)
    begin
      next_st.state = st_addr;
      next_st.bit_cnt = 4'h0;
      next_st.drive_low = 1'b0;
    end
    else if (stop_seen)
    begin
      next_st.state = st_idle;
      next_st.drive_low = 1'b0;
    end
    else
    begin
      case (st.state)
        st_idle:
        begin
          next_st.drive_low = 1'b0;
        end
        st_addr, st_wdata:
        begin
          if (scl_rise)
          begin
            next_st.shreg = {st.shreg[6:0], sda_in};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
          else if (scl_fall && st.bit_cnt == `ADDR_BITS)
          begin
            if (st.state == st_wdata)
            begin
              next_st.state = st_wack;
              next_st.drive_low = 1'b1;
              if (st.cmd == `CMD_CTRL)
              begin
                next_st.ctrl = st.shreg;
              end
              else if (nv_cmd(st.cmd))
              begin
                next_st.nv.we = 1'b1;
                next_st.nv.addr = nv_slot(st.cmd);
                next_st.nv.data = st.shreg;
              end
            end
            else if (st.shreg[7:5] == `DEV_CODE)
            begin
              next_st.state = st_addr_ack;
              next_st.cmd = st.shreg[4:1];
              next_st.rw = st.shreg[0];
              next_st.drive_low = 1'b1;
            end
            else
            begin
              next_st.state = st_idle;
            end
          end
        end
        st_addr_ack, st_wack:
        begin
          if (scl_fall)
          begin
            next_st.bit_cnt = 4'h0;
            if (st.state == st_addr_ack && st.rw)
            begin
              next_st.state = st_rdata;
              next_st.shreg = rd;
              next_st.drive_low = !rd[7];
            end
            else
            begin
              next_st.state = st_wdata;
              next_st.drive_low = 1'b0;
            end
          end
        end
        st_rdata:
        begin
          if (scl_rise)
          begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (st.bit_cnt == `ADDR_BITS)
            begin
              next_st.state = st_rack;
              next_st.drive_low = 1'b0;
            end
            else
            begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.drive_low = !st.shreg[6];
            end
          end
        end
        st_rack:
        begin
          if (scl_rise)
          begin
            next_st.ack_seen = !sda_in;
          end
          else if (scl_fall)
          begin
            next_st.bit_cnt = 4'h0;
            if (st.ack_seen)
            begin
              next_st.state = st_rdata;
              next_st.shreg = rd;
              next_st.drive_low = !rd[7];
            end
            else
            begin
              next_st.state = st_idle;
            end
          end
        end
        default:
        begin
          next_st.state = st_idle;
          next_st.drive_low = 1'b0;
        end
      endcase
    end

    // stored defaults applied once after reset
    if (!st.booted)
    begin
      next_st.booted = 1'b1;
      next_st.ctrl = nv[0];
    end

    // timer: rise restarts, low level halts
    if (timer_enable_in_rise)
    begin
      next_st.running = 1'b1;
      next_st.elapsed = 8'h00;
      next_st.tick_cnt = 6'h00;
      next_st.inv = 4'h0;
    end
    else if (!timer_enable_in)
    begin
      next_st.running = 1'b0;
    end
    else if (st.running)
    begin
      next_st.inv = st.inv | due;
      next_st.tick_cnt = tick ? 6'h00 : st.tick_cnt + 6'h01;
      if (tick && st.elapsed != 8'hff)
      begin
        next_st.elapsed = st.elapsed + 8'h01;
      end
    end

    // outputs: lower nibble may invert, upper never does
    next_st.dout = {st.ctrl[7:4], st.ctrl[3:0] ^ st.inv};
  end

  // ========================================================
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.state <= st_idle;
      st.ctrl <= `CTRL_RESET;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ========================================================
  // pins; the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = !st.drive_low;
  assign timed_out_0 = st.dout[0];
  assign timed_out_1 = st.dout[1];
  assign timed_out_2 = st.dout[2];
  assign timed_out_3 = st.dout[3];
  assign fixed_out_4 = st.dout[4];
  assign fixed_out_5 = st.dout[5];
  assign fixed_out_6 = st.dout[6];
  assign fixed_out_7 = st.dout[7];

  // ========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_sda_low_only: assert property (
    !sda_oe_n |-> st.state inside {st_addr_ack, st_wack, st_rdata})
    else $error("sda driven outside ack or read");
  chk_count_on_edge: assert property (
    st.bit_cnt != $past(st.bit_cnt) |->
      $past(scl_rise || scl_fall || start_seen))
    else $error("bit count moved without scl edge");
  chk_wp_blocks_nv: assert property (
    st.nv.we && wp_in |=> nv == $past(nv))
    else $error("nonvolatile write under protect");
  chk_ctrl_ignores_wp: assert property (
    scl_fall && st.state == st_wdata && st.bit_cnt == 4'h8 &&
      st.cmd == `CMD_CTRL && !start_seen && !stop_seen
      |=> st.ctrl == $past(st.shreg) ##1 st.state == st_wack)
    else $error("control write lost");
  chk_start_clears: assert property (
    timer_enable_in_rise |=> st.running && st.inv == 4'h0 && st.elapsed == 8'h00)
    else $error("timer start did not restart");
  chk_low_halts: assert property (
    !timer_enable_in ##1 !timer_enable_in |=>
      $stable(st.elapsed) && $stable(st.inv))
    else $error("timer moved while disabled");
  chk_lower_invert: assert property (
    ##1 {timed_out_3, timed_out_2, timed_out_1, timed_out_0} ==
      $past(st.ctrl[3:0] ^ st.inv))
    else $error("lower outputs wrong");
  // upper pins follow the control byte one cycle late, never the timer
  chk_upper_fixed: assert property (
    ##1 {fixed_out_7, fixed_out_6, fixed_out_5, fixed_out_4} ==
      $past(st.ctrl[7:4]))
    else $error("upper outputs wrong");
  chk_boot_defaults: assert property (
    !st.booted |=> st.ctrl == $past(nv[0]) && st.booted)
    else $error("defaults not applied");
  chk_bad_code_idle: assert property (
    st.state == st_addr && scl_fall && st.bit_cnt == 4'h8 &&
      st.shreg[7:5] != `DEV_CODE && !start_seen && !stop_seen
      |=> st.state == st_idle && sda_oe_n)
    else $error("foreign device code answered");

  cov_timer_invert: cover property (st.running && st.inv != 4'h0);
  cov_write_ack: cover property (st.state == st_wack);
  cov_read_byte: cover property (st.state == st_rack && st.ack_seen);

endmodule

// File: bench/serial_master_model.sv
// two-wire bus master model for the expander's serial pins
// assumes the bench resolves the wired data line with a pull-up
`timescale 1ns/1ps

module serial_master_model
(
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // ========================================================
  // bus timing: 120 system cycles a bit, about 333 kHz
  localparam int half = 60;

  // bus idle, data released
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // data falls while clock is high
  task automatic start_cond();
    sda_drv = 1'b1;
    pause(half);
    scl = 1'b1;
    pause(half);
    sda_drv = 1'b0;
    pause(half);
    scl = 1'b0;
  endtask

  // data rises while clock is high
  task automatic stop_cond();
    pause(4);
    sda_drv = 1'b0;
    pause(half);
    scl = 1'b1;
    pause(half);
    sda_drv = 1'b1;
    pause(half);
  endtask

  // nine clocks, msb first; a one bit leaves the line released
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      pause(4);
      sda_drv = tx[i];
      pause(half - 4);
      scl = 1'b1;
      pause(half / 2);
      rx[i] = sda_line;
      pause(half / 2);
      scl = 1'b0;
    end
  endtask
endmodule

// File: bench/timed_output_port_expander_tb.sv
// self-checking bench for the timed output port expander
// assumes the master model and design sources compile first
`timescale 1ns/1ps
`include "port_expander_defines.svh"

module timed_output_port_expander_tb;
  import port_expander_pkg::*;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wp_in = 1'b0;
  logic timer_enable_in = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_line;
  logic sda_out;
  logic sda_oe_n;
  logic ack;
  logic [7:0] outs;
  logic [7:0] rd_val;
  logic [3:0] odd_cmd;
  logic [2:0] bad_codes [2] = '{3'h0, 3'h5};
  int n_errors = 0;
  int checks = 0;
  int m_ctrl = 0;
  int m_nv [5] = '{0, 0, 0, 0, 0};
  int dly [4] = '{0, 3, 12, 200};

  // ========================================================
  // clock and wired data line with pull-up
  always #12.5 sys_clk = ~sys_clk;
  assign sda_line = (sda_oe_n | sda_out) & sda_drv;

  serial_master_model mst (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda_drv(sda_drv));

  timed_output_port_expander DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wp_in(wp_in),
    .timer_enable_in(timer_enable_in), .timed_out_0(outs[0]),
    .timed_out_1(outs[1]), .timed_out_2(outs[2]), .timed_out_3(outs[3]),
    .fixed_out_4(outs[4]), .fixed_out_5(outs[5]), .fixed_out_6(outs[6]),
    .fixed_out_7(outs[7]));

  // ========================================================
  // checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // expected pins: control byte, lower bits flipped once due
  function automatic logic [7:0] exp_out(input int elapsed);
    logic [7:0] e;
    e = m_ctrl[7:0];
    for (int i = 0; i < 4; i++)
      if (elapsed >= 0 && dly[i] <= elapsed)
        e[i] = ~e[i];
    return e;
  endfunction

  // ========================================================
  // bus transfers, model updated alongside
  task automatic wr(input logic [2:0] dc, input logic [3:0] cmd,
    input logic [7:0] d);
    logic [8:0] r1;
    logic [8:0] r2;
    mst.start_cond();
    mst.xfer({dc, cmd, 1'b0, 1'b1}, r1);
    mst.xfer({d, 1'b1}, r2);
    mst.stop_cond();
    ack = ~r1[0];
    if (dc == `DEV_CODE && cmd == `CMD_CTRL)
      m_ctrl = d;
    else if (dc == `DEV_CODE && cmd <= `CMD_NV_LAST && !wp_in)
      m_nv[cmd - 1] = d;
  endtask

  task automatic rd(input logic [3:0] cmd);
    logic [8:0] r1;
    logic [8:0] r2;
    mst.start_cond();
    mst.xfer({`DEV_CODE, cmd, 1'b1, 1'b1}, r1);
    mst.xfer({8'hff, 1'b1}, r2);
    mst.stop_cond();
    rd_val = r2[8:1];
  endtask

  // two bytes from one command, the first acked by the master
  task automatic rd_two(input logic [3:0] cmd, input logic [7:0] exp);
    logic [8:0] r1;
    logic [8:0] r2;
    logic [8:0] r3;
    mst.start_cond();
    mst.xfer({`DEV_CODE, cmd, 1'b1, 1'b1}, r1);
    mst.xfer({8'hff, 1'b0}, r2);
    mst.xfer({8'hff, 1'b1}, r3);
    mst.stop_cond();
    check({7'h00, r1[0]}, 8'h00);
    check(r2[8:1], exp);
    check(r3[8:1], exp);
  endtask

  task automatic do_reset(input int n);
    reset_n = 1'b0;
    repeat (n) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    m_ctrl = m_nv[0];
  endtask

  task automatic ticks(input int n);
    repeat (n * `TICK_CYC) @(negedge sys_clk);
  endtask

  // watchdog
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  // ========================================================
  // main sequence
  initial
  begin
    void'($urandom(68598));
    do_reset(12);
    check(outs, exp_out(-1));
    check({7'h00, sda_oe_n}, 8'h01);
    check({7'h00, sda_out}, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      wp_in = k[0];
      wr(`DEV_CODE, `CMD_CTRL, 8'($urandom));
      check({7'h00, ack}, 8'h01);
      check(outs, exp_out(-1));
      rd(`CMD_CTRL);
      check(rd_val, m_ctrl[7:0]);
    end
    foreach (bad_codes[j])
    begin
      wr(bad_codes[j], `CMD_CTRL, ~m_ctrl[7:0]);
      check({7'h00, ack}, 8'h00);
      check(outs, exp_out(-1));
    end
    wp_in = 1'b1;
    wr(`DEV_CODE, `CMD_NV_DEF, 8'($urandom));
    rd(`CMD_NV_DEF);
    check(rd_val, m_nv[0][7:0]);
    wp_in = 1'b0;
    wr(`DEV_CODE, `CMD_NV_DEF, 8'($urandom));
    for (int i = 0; i < 4; i++)
      wr(`DEV_CODE, 4'(`CMD_NV_DLY0 + i), dly[i][7:0]);
    rd(`CMD_NV_DEF);
    check(rd_val, m_nv[0][7:0]);
    for (int i = 0; i < 4; i++)
      rd_two(4'(`CMD_NV_DLY0 + i), m_nv[i + 1][7:0]);
    odd_cmd = 4'(6 + $urandom % 10);
    wr(`DEV_CODE, odd_cmd, 8'($urandom));
    check({7'h00, ack}, 8'h01);
    check(outs, exp_out(-1));
    rd(odd_cmd);
    check(rd_val, 8'h00);
    do_reset(3);
    check(outs, exp_out(-1));
    timer_enable_in = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(outs, exp_out(0));
    ticks(8);
    check(outs, exp_out(8));
    timer_enable_in = 1'b0;
    ticks(20);
    check(outs, exp_out(8));
    timer_enable_in = 1'b1;
    ticks(2);
    check(outs, exp_out(2));
    ticks(12);
    check(outs, exp_out(14));
    wr(`DEV_CODE, `CMD_CTRL, 8'($urandom));
    check(outs, exp_out(100));
    give_verdict();
  end
endmodule
